// >>> rtl/tccf_pkg.sv
// constants and types for the timer compare/capture and request flag block
package tccf_pkg;

    // ------------------------------------------------------------
    // register addresses on the special function register bus
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_IRQ_FLAGS    = 8'hC0;
    localparam logic [7:0] ADDR_MODE_SELECT  = 8'hC1;
    localparam logic [7:0] ADDR_CH_ONE_LOW   = 8'hC2;
    localparam logic [7:0] ADDR_CH_ONE_HIGH  = 8'hC3;
    localparam logic [7:0] ADDR_CH_TWO_LOW   = 8'hC4;
    localparam logic [7:0] ADDR_CH_TWO_HIGH  = 8'hC5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_IRQ_FLAGS   = 8'h00;
    localparam logic [7:0]  RST_MODE_SELECT = 8'h00;
    localparam logic [15:0] RST_CH_VALUE    = 16'h0000;
    localparam logic [7:0]  RST_READ_DATA   = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_W       = 2;
    localparam int MODE_LSB_CH0 = 0;
    localparam int MODE_LSB_CH1 = 2;
    localparam int MODE_LSB_CH2 = 4;
    localparam int MODE_LSB_CH3 = 6;

    localparam int FLAG_RELOAD   = 7;
    localparam int FLAG_OVERFLOW = 6;
    localparam int FLAG_EXT_LSB  = 1;
    localparam int FLAG_EXT_W    = 5;
    localparam int FLAG_CONVERT  = 0;
    // bit 0 belongs to a converter this device lacks: never held
    localparam logic [7:0] FLAG_KEEP_MASK = 8'hFE;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_PIN   = 2'b01,
        MODE_CMP   = 2'b10,
        MODE_WRCAP = 2'b11
    } tccf_mode_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tccf_sfr_req_type;

endpackage

// >>> rtl/tccf_top.sv
// compare/capture front end for timer two and the interrupt request flags

module tccf_top (
    // clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_srst,
    // special function register bus
    input  wire tccf_pkg::tccf_sfr_req_type i_sfr_req,
    output logic                           o_sfr_sel,
    output logic [7:0]                     o_sfr_rdata,
    // timer two
    input  wire logic [15:0]               i_timer_count,
    input  wire logic                      i_timer_reload_evt,
    input  wire logic                      i_timer_overflow_evt,
    // external interrupt edge events, irq two to six
    input  wire logic [4:0]                i_ext_irq_edge_evt,
    input  wire logic                      i_ext_irq_three_edge_select,
    // capture pins, index is channel number
    input  wire logic [3:0]                i_channel_capture_pin,
    // channel outputs
    output logic [1:0]                     o_compare_match,
    output logic [1:0]                     o_capture_evt,
    output logic                           o_channel_zero_capture,
    output logic [1:0]                     o_channel_three_mode
);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire logic [7:0] addr  = i_sfr_req.addr;
    wire logic [7:0] wdata = i_sfr_req.wdata;
    wire logic       wr    = i_sfr_req.wr;
    wire logic       rd    = i_sfr_req.rd;

    wire logic hit_flags = (addr == tccf_pkg::ADDR_IRQ_FLAGS);
    wire logic hit_mode  = (addr == tccf_pkg::ADDR_MODE_SELECT);
    wire logic hit_c1_lo = (addr == tccf_pkg::ADDR_CH_ONE_LOW);
    wire logic hit_c1_hi = (addr == tccf_pkg::ADDR_CH_ONE_HIGH);
    wire logic hit_c2_lo = (addr == tccf_pkg::ADDR_CH_TWO_LOW);
    wire logic hit_c2_hi = (addr == tccf_pkg::ADDR_CH_TWO_HIGH);

    wire logic [1:0] hit_lo = {hit_c2_lo, hit_c1_lo};
    wire logic [1:0] hit_hi = {hit_c2_hi, hit_c1_hi};

    assign o_sfr_sel = hit_flags | hit_mode | (|hit_lo) | (|hit_hi);

    // write strobes per register
    wire logic mode_wr = wr && hit_mode;
    wire logic flag_wr = wr && hit_flags;

    // ------------------------------------------------------------
    // mode select register
    // ------------------------------------------------------------
    logic [7:0] mode_select_r;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            mode_select_r <= tccf_pkg::RST_MODE_SELECT;
        end else if (mode_wr) begin
            mode_select_r <= wdata;
        end
    end

    wire tccf_pkg::tccf_mode_type mode_ch0 =
        tccf_pkg::tccf_mode_type'(mode_select_r[tccf_pkg::MODE_LSB_CH0 +: tccf_pkg::MODE_W]);
    wire tccf_pkg::tccf_mode_type mode_ch1 =
        tccf_pkg::tccf_mode_type'(mode_select_r[tccf_pkg::MODE_LSB_CH1 +: tccf_pkg::MODE_W]);
    wire tccf_pkg::tccf_mode_type mode_ch2 =
        tccf_pkg::tccf_mode_type'(mode_select_r[tccf_pkg::MODE_LSB_CH2 +: tccf_pkg::MODE_W]);

    // channel three data lives elsewhere; only its mode is exported
    assign o_channel_three_mode =
        mode_select_r[tccf_pkg::MODE_LSB_CH3 +: tccf_pkg::MODE_W];

    // index 0 is channel one, index 1 channel two
    wire tccf_pkg::tccf_mode_type mode_ch [2];
    assign mode_ch[0] = mode_ch1;
    assign mode_ch[1] = mode_ch2;

    // ------------------------------------------------------------
    // capture pin edge detection
    // ------------------------------------------------------------
    logic [3:0] pin_prev_r;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            pin_prev_r <= 4'h0;
        end else begin
            pin_prev_r <= i_channel_capture_pin;
        end
    end

    wire logic [3:0] pin_rise = i_channel_capture_pin & ~pin_prev_r;
    wire logic [3:0] pin_fall = ~i_channel_capture_pin & pin_prev_r;

    // ------------------------------------------------------------
    // channel zero capture pulse
    // ------------------------------------------------------------
    // channel zero follows the irq three edge select; its register is external
    wire logic ch0_edge = i_ext_irq_three_edge_select ? pin_rise[0] : pin_fall[0];
    wire logic ch0_cap  = (mode_ch0 == tccf_pkg::MODE_PIN) && ch0_edge;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_channel_zero_capture <= 1'b0;
        end else begin
            o_channel_zero_capture <= ch0_cap;
        end
    end

    // ------------------------------------------------------------
    // channels one and two: next values
    // ------------------------------------------------------------
    logic [15:0]      value_r   [2];
    wire logic [15:0] value_nxt [2];
    wire logic [1:0]  match_nxt;
    wire logic [1:0]  cap_nxt;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            wire logic wr_lo    = wr && hit_lo[ch];
            wire logic wr_hi    = wr && hit_hi[ch];
            // pins of channels one and two capture on the rising edge only
            wire logic cap_pin  = (mode_ch[ch] == tccf_pkg::MODE_PIN) && pin_rise[ch + 1];
            wire logic cap_wr   = (mode_ch[ch] == tccf_pkg::MODE_WRCAP) && (wr_lo || wr_hi);
            wire logic do_cap   = cap_pin || cap_wr;
            wire logic is_match = (mode_ch[ch] == tccf_pkg::MODE_CMP)
                                  && (value_r[ch] == i_timer_count);

            // a write in write-capture mode latches the count, not the data
            assign value_nxt[ch] = do_cap ? i_timer_count :
                                   wr_lo  ? {value_r[ch][15:8], wdata} :
                                   wr_hi  ? {wdata, value_r[ch][7:0]}  :
                                   value_r[ch];
            assign match_nxt[ch] = is_match;
            assign cap_nxt[ch]   = do_cap;
        end
    endgenerate

    // ------------------------------------------------------------
    // channels one and two: registers
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            value_r         <= '{default: tccf_pkg::RST_CH_VALUE};
            o_compare_match <= 2'b00;
            o_capture_evt   <= 2'b00;
        end else begin
            value_r         <= value_nxt;
            o_compare_match <= match_nxt;
            o_capture_evt   <= cap_nxt;
        end
    end

    // ------------------------------------------------------------
    // interrupt request flags
    // ------------------------------------------------------------
    logic [7:0] irq_flags_r;
    logic [7:0] irq_flags_nxt;
    logic [7:0] flag_set;

    always_comb begin
        flag_set = 8'h00;
        flag_set[tccf_pkg::FLAG_RELOAD]   = i_timer_reload_evt;
        flag_set[tccf_pkg::FLAG_OVERFLOW] = i_timer_overflow_evt;
        flag_set[tccf_pkg::FLAG_EXT_LSB +: tccf_pkg::FLAG_EXT_W] = i_ext_irq_edge_evt;
    end

    // a hardware set in the same cycle as a software write wins
    wire logic [7:0] flag_base = flag_wr ? wdata : irq_flags_r;
    assign irq_flags_nxt = flag_base | flag_set;

    // bit 0 is masked off so the converter flag never sets
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            irq_flags_r <= tccf_pkg::RST_IRQ_FLAGS;
        end else begin
            irq_flags_r <= irq_flags_nxt & tccf_pkg::FLAG_KEEP_MASK;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire logic [7:0] c1_lo_q = value_r[0][7:0];
    wire logic [7:0] c1_hi_q = value_r[0][15:8];
    wire logic [7:0] c2_lo_q = value_r[1][7:0];
    wire logic [7:0] c2_hi_q = value_r[1][15:8];

    wire logic [7:0] rd_mux =
        hit_flags ? irq_flags_r :
        hit_mode  ? mode_select_r :
        hit_c1_lo ? c1_lo_q :
        hit_c1_hi ? c1_hi_q :
        hit_c2_lo ? c2_lo_q :
        hit_c2_hi ? c2_hi_q :
        tccf_pkg::RST_READ_DATA;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_sfr_rdata <= tccf_pkg::RST_READ_DATA;
        end else if (rd) begin
            o_sfr_rdata <= rd_mux;
        end
    end

endmodule

// >>> verif/tb.sv
// self-checking bench for the compare/capture and flag block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    tccf_pkg::tccf_sfr_req_type req;
    logic        clk, srst, sel, rld, ovf, esel, cap0;
    logic [7:0]  rdata, d;
    logic [15:0] cnt;
    logic [4:0]  ext;
    logic [3:0]  pin;
    logic [1:0]  match, cap, mode3;
    int          fails, comparisons;
    tccf_top dut (.i_mclk(clk), .i_srst(srst), .i_sfr_req(req), .o_sfr_sel(sel),
        .o_sfr_rdata(rdata), .i_timer_count(cnt), .i_timer_reload_evt(rld),
        .i_timer_overflow_evt(ovf), .i_ext_irq_edge_evt(ext), .i_ext_irq_three_edge_select(esel),
        .i_channel_capture_pin(pin), .o_compare_match(match), .o_capture_evt(cap),
        .o_channel_zero_capture(cap0), .o_channel_three_mode(mode3));
    tccf_core_model core (.i_mclk(clk), .i_rdata(rdata), .o_req(req));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        core.rd(a, d);
        chk("read data", 16'(e), 16'(d));
    endtask
    task automatic s_regs;
        for (int i = 0; i < 7; i++) rdchk(8'hC0 + 8'(i), 8'h00);
        core.wr(8'hC1, 8'hC0);
        chk("ch3 mode", 16'h0003, 16'(mode3));
        core.wr(8'hC2, 8'h5A);
        core.wr(8'hC3, 8'hA5);
        core.wr(8'hC4, 8'h3C);
        core.wr(8'hC5, 8'hC3);
        rdchk(8'hC2, 8'h5A);
        rdchk(8'hC3, 8'hA5);
        rdchk(8'hC4, 8'h3C);
        rdchk(8'hC5, 8'hC3);
        core.wr(8'hC1, 8'h00);
    endtask
    task automatic s_flags;
        for (int i = 0; i < 7; i++) begin
            {rld, ovf, ext} = 7'(7'h01 << i);
            step;
            {rld, ovf, ext} = 7'h00;
            rdchk(8'hC0, 8'(8'h02 << i));
            core.wr(8'hC0, 8'h00);
        end
        ovf = 1'b1;
        fork
            core.wr(8'hC0, 8'h00);
            begin
                step;
                ovf = 1'b0;
            end
        join
        rdchk(8'hC0, 8'h40);
        core.wr(8'hC0, 8'h00);
        core.wr(8'hC0, 8'hFF);
        rdchk(8'hC0, 8'hFE);
        core.wr(8'hC0, 8'h00);
    endtask
    task automatic s_chan(input int ch);
        logic [7:0] b;
        b = 8'hC0 + 8'(2 * ch);
        core.wr(8'hC1, 8'(8'h01 << 2 * ch));
        cnt = 16'hA5C3 + 16'(ch);
        pin[ch] = 1'b1;
        step;
        chk("capture pulse", 16'(ch), 16'(cap));
        pin[ch] = 1'b0;
        rdchk(b, cnt[7:0]);
        rdchk(b + 8'h01, cnt[15:8]);
        core.wr(8'hC1, 8'(8'h03 << 2 * ch));
        cnt = 16'h1234;
        core.wr(b, 8'hFF);
        rdchk(b, 8'h34);
        rdchk(b + 8'h01, 8'h12);
        core.wr(8'hC1, 8'(8'h02 << 2 * ch));
        core.wr(b, 8'h77);
        core.wr(b + 8'h01, 8'h00);
        cnt = 16'h0077;
        step;
        chk("match", 16'(ch), 16'(match));
        cnt = 16'h0000;
        step;
        chk("match", 16'h0000, 16'(match));
        core.wr(8'hC1, 8'h00);
        pin[ch] = 1'b1;
        step;
        chk("capture pulse", 16'h0000, 16'(cap));
        pin[ch] = 1'b0;
    endtask
    task automatic s_zero;
        core.wr(8'hC1, 8'h01);
        esel = 1'b1;
        pin[0] = 1'b1;
        step;
        chk("zero capture", 16'h0001, 16'(cap0));
        step;
        chk("zero capture", 16'h0000, 16'(cap0));
        esel = 1'b0;
        pin[0] = 1'b0;
        step;
        chk("zero capture", 16'h0001, 16'(cap0));
        step;
        chk("zero capture", 16'h0000, 16'(cap0));
        core.wr(8'hC1, 8'h00);
    endtask
    task automatic summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        {srst, rld, ovf, esel, ext, pin, cnt} = {1'b1, 28'h0};
        fails = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        #1 srst = 1'b0;
        s_regs;
        s_flags;
        s_chan(1);
        s_chan(2);
        s_zero;
        summarize;
    end
endmodule

// >>> verif/tccf_core_model.sv
// processor core model driving the register bus
module tccf_core_model (
    input  wire logic                  i_mclk,
    input  wire logic [7:0]            i_rdata,
    output tccf_pkg::tccf_sfr_req_type o_req
);
    timeunit 1ns;
    timeprecision 100ps;
    initial o_req = '0;
    // one access held over its taking edge, then one idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        o_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk);
        #1 o_req = '0;
        @(posedge i_mclk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        o_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        #1 o_req = '0;
        d = i_rdata;
        @(posedge i_mclk);
        #1;
    endtask
endmodule

// >>> verif/tccf_properties.sv
// bus, flag and mode checks on the compare/capture block ports
module tccf_properties (
    input wire logic                       i_mclk,
    input wire logic                       i_srst,
    input wire tccf_pkg::tccf_sfr_req_type i_sfr_req,
    input wire logic                       o_sfr_sel,
    input wire logic [7:0]                 o_sfr_rdata,
    input wire logic                       i_timer_reload_evt,
    input wire logic                       i_timer_overflow_evt,
    input wire logic [1:0]                 o_channel_three_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    wire [7:0] a       = i_sfr_req.addr;
    wire [1:0] wd_top  = i_sfr_req.wdata[7:6];
    wire       rd_flag = i_sfr_req.rd && a == 8'hC0;
    wire       wr_mode = i_sfr_req.wr && a == 8'hC1;
    sel_decode_a: assert property (o_sfr_sel == (a >= 8'hC0 && a <= 8'hC5))
        else $error("select decode wrong");
    conv_clear_a: assert property (rd_flag |=> !o_sfr_rdata[0])
        else $error("converter flag read as set");
    ovf_flag_a: assert property (i_timer_overflow_evt ##1 rd_flag |=> o_sfr_rdata[6])
        else $error("overflow flag not set");
    reload_flag_a: assert property (i_timer_reload_evt ##1 rd_flag |=> o_sfr_rdata[7])
        else $error("reload flag not set");
    mode_write_a: assert property (wr_mode |=> o_channel_three_mode == $past(wd_top))
        else $error("channel three mode not loaded");
    mode_hold_a: assert property ($changed(o_channel_three_mode) |-> $past(wr_mode))
        else $error("channel three mode changed alone");
    rdata_hold_a: assert property (!i_sfr_req.rd |=> $stable(o_sfr_rdata))
        else $error("read data moved without read");
    unmapped_read_a: assert property (i_sfr_req.rd && !o_sfr_sel |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind tccf_top tccf_properties u_props (.i_mclk(i_mclk), .i_srst(i_srst), .i_sfr_req(i_sfr_req),
    .o_sfr_sel(o_sfr_sel), .o_sfr_rdata(o_sfr_rdata), .i_timer_reload_evt(i_timer_reload_evt),
    .i_timer_overflow_evt(i_timer_overflow_evt), .o_channel_three_mode(o_channel_three_mode));
